//--- pic_device_end.sv
`timescale 1ns/1ps
// Overview of operation
// - Control write with bit 4 is first init word
// - Init bit 2 selects 8 or 4 byte spacing
// - Control write with bits 4,3 zero is command
// - Codes 000/100 clear/set rotation on automatic end
// - 001 clears top in-service, 101 also rotates, 010 idles
// - 011 clears in-service bit of named level
// - 110 sets priority from named level
// - Three init writes follow on the data port
// - Control write with bits 4,3 = 01 is third word
module pic_device_end
  import pic_cmd_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host side.
  pic_port_if.device port,
  // Request lines and mode view.
  input wire logic [7:0] irq_lines,
  output logic level_mode,
  output logic spacing_four,
  output logic auto_rotate,
  output logic [5:0] call_offset
);

  init_state_t init_state;
  logic [7:0] req_prev;
  logic [7:0] irr;
  logic [7:0] isr;
  logic [7:0] mask;
  logic [2:0] lowest_pri;
  logic [4:0] vector_base;
  logic auto_end;
  logic read_isr;
  logic [7:0] set_req;
  logic [7:0] next_irr;
  logic [7:0] next_isr;
  logic [2:0] next_lowest;
  logic next_auto_rotate;

  // Scan levels from the lowest priority up to the top; the last hit, nearest the top, wins; returns found flag and level.
  function automatic logic [3:0] pick_top(input logic [7:0] vec, input logic [2:0] top);
    logic [3:0] res;
    logic [2:0] lvl;
    res = 4'h0;
    lvl = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      lvl = top + 3'(i);
      if (vec[lvl]) begin
        res = {1'b1, lvl};
      end
    end
    return res;
  endfunction

  // Port and command decode.
  wire wr_ctrl = port.io_wr && (port.io_addr == CTRL_PORT);
  wire wr_data = port.io_wr && (port.io_addr == DATA_PORT);
  wire is_init1 = wr_ctrl && port.io_wdata[SEL_INIT_BIT];
  wire is_op2 = wr_ctrl && !port.io_wdata[SEL_INIT_BIT] && !port.io_wdata[SEL_OP3_BIT];
  wire is_op3 = wr_ctrl && !port.io_wdata[SEL_INIT_BIT] && port.io_wdata[SEL_OP3_BIT];
  wire [2:0] cmd = port.io_wdata[CMD_HI:CMD_LO];
  wire [2:0] lvl_field = port.io_wdata[LVL_HI:0];

  // Priority resolution; the level after the lowest one is the highest.
  wire [2:0] top_pri = lowest_pri + 3'h1;
  wire [7:0] pending = irr & ~mask;
  wire [3:0] pend_pick = pick_top(pending, top_pri);
  wire [3:0] isr_pick = pick_top(isr, top_pri);
  wire pend_found = pend_pick[3];
  wire isr_found = isr_pick[3];
  wire [2:0] pend_lvl = pend_pick[2:0];
  wire [2:0] isr_lvl = isr_pick[2:0];
  wire [2:0] pend_rank = pend_lvl - top_pri;
  wire [2:0] isr_rank = isr_lvl - top_pri;
  wire next_irq = pend_found && (!isr_found || pend_rank < isr_rank);
  wire ack_hit = port.int_ack && pend_found;
  wire [2:0] ack_lvl = pend_found ? pend_lvl : SPURIOUS_LEVEL;
  wire [5:0] next_offset = spacing_four ? {1'b0, ack_lvl, 2'b00} : {ack_lvl, 3'b000};
  wire [7:0] read_value = (port.io_addr == DATA_PORT) ? mask : (read_isr ? isr : irr);
  wire mask_write = wr_data && (init_state == INIT_IDLE);

  // Request capture per line; a new request wins over a clear in the same cycle.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_req
      wire ack_clr = ack_hit && (pend_lvl == 3'(g));
      wire line_gone = level_mode && !irq_lines[g];
      assign set_req[g] = level_mode ? irq_lines[g] : (irq_lines[g] && !req_prev[g]);
      assign next_irr[g] = set_req[g] || (irr[g] && !ack_clr && !line_gone && !is_init1);
    end
  endgenerate

  // In-service, priority and rotation mode updates from acknowledges and commands.
  always_comb begin
    next_isr = isr;
    next_lowest = lowest_pri;
    next_auto_rotate = auto_rotate;
    if (ack_hit) begin
      next_isr[pend_lvl] = 1'b1;
      if (auto_end) begin
        next_isr[pend_lvl] = 1'b0;
        if (auto_rotate) begin
          next_lowest = pend_lvl;
        end
      end
    end
    if (is_op2) begin
      case (cmd)
        CMD_ROT_AEOI_CLR: next_auto_rotate = 1'b0;
        CMD_ROT_AEOI_SET: next_auto_rotate = 1'b1;
        CMD_END_NONSPEC: begin
          if (isr_found) begin
            next_isr[isr_lvl] = 1'b0;
          end
        end
        CMD_END_NONSPEC_ROT: begin
          if (isr_found) begin
            next_isr[isr_lvl] = 1'b0;
            next_lowest = isr_lvl;
          end
        end
        CMD_END_SPEC: next_isr[lvl_field] = 1'b0;
        CMD_END_SPEC_ROT: begin
          next_isr[lvl_field] = 1'b0;
          next_lowest = lvl_field;
        end
        CMD_SET_PRIORITY: next_lowest = lvl_field;
        CMD_NO_ACTION: next_lowest = lowest_pri;
        default: next_lowest = lowest_pri;
      endcase
    end
    if (is_init1) begin
      next_isr = 8'h00;
      next_lowest = LOWEST_PRI_RESET;
    end
  end

  // Interrupt state registers.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_prev <= 8'h00;
      irr <= 8'h00;
      isr <= 8'h00;
      lowest_pri <= LOWEST_PRI_RESET;
      auto_rotate <= 1'b0;
      port.irq_out <= 1'b0;
    end else begin
      req_prev <= irq_lines;
      irr <= next_irr;
      isr <= next_isr;
      lowest_pri <= next_lowest;
      auto_rotate <= next_auto_rotate;
      port.irq_out <= next_irq;
    end
  end

  // Initialization sequence; a new first word always restarts it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_state <= INIT_IDLE;
      level_mode <= 1'b0;
      spacing_four <= 1'b0;
      vector_base <= BASE_RESET;
      auto_end <= 1'b0;
    end else if (is_init1) begin
      init_state <= INIT_WAIT_SECOND;
      level_mode <= port.io_wdata[TRIG_MODE_BIT];
      spacing_four <= port.io_wdata[SPACING_BIT];
      auto_end <= 1'b0;
    end else if (wr_data) begin
      case (init_state)
        INIT_WAIT_SECOND: begin
          vector_base <= port.io_wdata[BASE_HI:BASE_LO];
          init_state <= INIT_WAIT_THIRD;
        end
        INIT_WAIT_THIRD: init_state <= INIT_WAIT_FOURTH;
        INIT_WAIT_FOURTH: begin
          auto_end <= port.io_wdata[AUTO_END_BIT];
          init_state <= INIT_IDLE;
        end
        default: init_state <= INIT_IDLE;
      endcase
    end
  end

  // Mask writes and the read selection of the third operation word.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= MASK_RESET;
      read_isr <= 1'b0;
    end else if (is_init1) begin
      mask <= MASK_RESET;
      read_isr <= 1'b0;
    end else if (mask_write) begin
      mask <= port.io_wdata;
    end else if (is_op3 && port.io_wdata[READ_ENA_BIT]) begin
      read_isr <= port.io_wdata[READ_ISR_BIT];
    end
  end

  // Read data and acknowledge vector; the offset is the call spacing from the base.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port.io_rdata <= 8'h00;
      call_offset <= 6'h00;
    end else if (port.int_ack) begin
      port.io_rdata <= {vector_base, ack_lvl};
      call_offset <= next_offset;
    end else if (port.io_rd) begin
      port.io_rdata <= read_value;
    end
  end

endmodule

//--- pic_cmd_pkg.sv
// Shared constants for the interrupt command decoder and its host-side driver.
package pic_cmd_pkg;

  // Port addresses on the I/O bus.
  localparam logic [15:0] CTRL_PORT = 16'h0020;
  localparam logic [15:0] DATA_PORT = 16'h0021;

  // Field positions inside the written byte.
  localparam int SEL_INIT_BIT = 4;
  localparam int SEL_OP3_BIT = 3;
  localparam int TRIG_MODE_BIT = 3;
  localparam int SPACING_BIT = 2;
  localparam int AUTO_END_BIT = 1;
  localparam int READ_ISR_BIT = 0;
  localparam int READ_ENA_BIT = 1;
  localparam int CMD_HI = 7;
  localparam int CMD_LO = 5;
  localparam int LVL_HI = 2;
  localparam int BASE_HI = 7;
  localparam int BASE_LO = 3;

  // Command codes of the second operation word.
  localparam logic [2:0] CMD_ROT_AEOI_CLR = 3'h0;
  localparam logic [2:0] CMD_END_NONSPEC = 3'h1;
  localparam logic [2:0] CMD_NO_ACTION = 3'h2;
  localparam logic [2:0] CMD_END_SPEC = 3'h3;
  localparam logic [2:0] CMD_ROT_AEOI_SET = 3'h4;
  localparam logic [2:0] CMD_END_NONSPEC_ROT = 3'h5;
  localparam logic [2:0] CMD_SET_PRIORITY = 3'h6;
  localparam logic [2:0] CMD_END_SPEC_ROT = 3'h7;

  // Reset values and the level given for a spurious acknowledge.
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] LOWEST_PRI_RESET = 3'h7;
  localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;
  localparam logic [4:0] BASE_RESET = 5'h00;

  // Number of data-port writes that follow the first initialization word.
  localparam logic [1:0] INIT_FOLLOW_WRITES = 2'h3;

  // Host command kinds.
  localparam logic [1:0] KIND_WRITE = 2'h0;
  localparam logic [1:0] KIND_READ = 2'h1;
  localparam logic [1:0] KIND_ACK = 2'h2;

  typedef enum logic [1:0] {
    INIT_IDLE,
    INIT_WAIT_SECOND,
    INIT_WAIT_THIRD,
    INIT_WAIT_FOURTH
  } init_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_ISSUED,
    HOST_CAPTURE
  } host_state_t;

endpackage

//--- pic_port_if.sv
`timescale 1ns/1ps
// I/O port connection between the host processor and the interrupt controller.
interface pic_port_if;
  logic io_wr;
  logic io_rd;
  logic int_ack;
  logic [15:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic irq_out;

  modport device (
    input io_wr,
    input io_rd,
    input int_ack,
    input io_addr,
    input io_wdata,
    output io_rdata,
    output irq_out
  );

  modport host (
    output io_wr,
    output io_rd,
    output int_ack,
    output io_addr,
    output io_wdata,
    input io_rdata,
    input irq_out
  );
endinterface

//--- pic_host_end.sv
`timescale 1ns/1ps
module pic_host_end
  import pic_cmd_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Controller side.
  pic_port_if.host port,
  // User command side.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_kind,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // User answer side.
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic irq_pending
);

  host_state_t state;
  logic [1:0] init_left;

  // Decode of the offered command.
  wire is_write = cmd_kind == KIND_WRITE;
  wire to_ctrl = cmd_addr == CTRL_PORT;
  wire to_data = cmd_addr == DATA_PORT;
  wire starts_init = is_write && to_ctrl && cmd_data[SEL_INIT_BIT];
  // While the init sequence runs only data-port writes may pass, so nothing breaks it.
  wire refuse = (init_left != 2'h0) && !(is_write && to_data);
  wire accept = cmd_valid && cmd_ready;
  // Reserved top bits of the first init word are forced to zero.
  wire [7:0] out_data = starts_init ? {3'b000, cmd_data[4:0]} : cmd_data;

  assign cmd_ready = (state == HOST_IDLE) && !refuse;
  assign irq_pending = port.irq_out;

  // Drive the I/O strobes for one cycle per accepted command.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port.io_wr <= 1'b0;
      port.io_rd <= 1'b0;
      port.int_ack <= 1'b0;
      port.io_addr <= 16'h0000;
      port.io_wdata <= 8'h00;
    end else begin
      port.io_wr <= accept && is_write;
      port.io_rd <= accept && (cmd_kind == KIND_READ);
      port.int_ack <= accept && (cmd_kind == KIND_ACK);
      if (accept) begin
        port.io_addr <= cmd_addr;
        // Level fields are three bits wide, so every level sent is a valid one.
        port.io_wdata <= out_data;
      end
    end
  end

  // Count the init writes still owed to the data port.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_left <= 2'h0;
    end else if (accept && starts_init) begin
      init_left <= INIT_FOLLOW_WRITES;
    end else if (accept && is_write && to_data && init_left != 2'h0) begin
      init_left <= init_left - 2'h1;
    end
  end

  // Reads and acknowledges wait for the controller's registered answer.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HOST_IDLE;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        HOST_IDLE: begin
          if (accept && !is_write) begin
            state <= HOST_ISSUED;
          end
        end
        HOST_ISSUED: begin
          state <= HOST_CAPTURE;
        end
        HOST_CAPTURE: begin
          rsp_valid <= 1'b1;
          rsp_data <= port.io_rdata;
          state <= HOST_IDLE;
        end
        default: begin
          state <= HOST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- pic_cmd_properties.sv
`timescale 1ns/1ps
// Watches the port writes and the mode view of the device end.
module pic_cmd_properties
  import pic_cmd_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Port writes.
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  // Mode view.
  input wire logic level_mode,
  input wire logic spacing_four,
  input wire logic auto_rotate
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Writes are split by their select bits, so each check sees only its own word.
  wire logic ctl = io_wr && io_addr == CTRL_PORT;
  wire logic init1 = ctl && io_wdata[4];
  wire logic op2 = ctl && io_wdata[4:3] == 2'h0;
  wire logic [2:0] code = io_wdata[7:5];
  wire logic [2:0] cfg = {level_mode, spacing_four, auto_rotate};

  a_init_reserved: assert property (init1 |-> io_wdata[7:5] == 3'h0)
    else $error("first init word carries nonzero upper bits");
  a_trigger_mode: assert property (init1 |=> level_mode == $past(io_wdata[3]))
    else $error("trigger mode not taken from init word");
  a_vector_spacing: assert property (init1 |=> spacing_four == $past(io_wdata[2]))
    else $error("vector spacing not taken from init word");
  a_command_select: assert property (op2 |=> $stable(cfg[2:1]))
    else $error("command word changed the init modes");
  a_rotate_clear: assert property (op2 && code == CMD_ROT_AEOI_CLR |=> !auto_rotate)
    else $error("rotation mode not cleared");
  a_rotate_set: assert property (op2 && code == CMD_ROT_AEOI_SET |=> auto_rotate)
    else $error("rotation mode not set");
  a_end_keeps_mode: assert property (op2 && code[1:0] != 2'h0 |=> $stable(cfg))
    else $error("end or priority command changed a mode");
  a_third_word: assert property (ctl && io_wdata[4:3] == 2'h1 |=> $stable(cfg))
    else $error("third word taken as another word");
  a_data_keeps: assert property (io_wr && io_addr == DATA_PORT |=> $stable(cfg))
    else $error("data port write changed a mode");
endmodule

//--- legacy_interrupt_command_decoder_bench.sv
`timescale 1ns/1ps
// Drives the host end with port commands and checks the device end's answers.
module legacy_interrupt_command_decoder_bench
  import pic_cmd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_kind = KIND_WRITE;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] irq_lines = 8'h00;
  logic cmd_ready, rsp_valid, irq_pending, level_mode, spacing_four, auto_rotate;
  logic [7:0] rsp_data;
  logic [5:0] call_offset;
  int mismatches = 0;
  int n_tests = 0;

  // Clock at 25 MHz.
  always #20 ref_clk = ~ref_clk;

  pic_port_if port ();
  pic_host_end u_pic_host_end (.ref_clk(ref_clk), .rst_n(rst_n), .port(port),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .irq_pending(irq_pending));
  pic_device_end u_pic_device_end (.ref_clk(ref_clk), .rst_n(rst_n), .port(port),
    .irq_lines(irq_lines), .level_mode(level_mode), .spacing_four(spacing_four),
    .auto_rotate(auto_rotate), .call_offset(call_offset));
  pic_cmd_properties u_pic_cmd_properties (.ref_clk(ref_clk), .rst_n(rst_n),
    .io_wr(port.io_wr), .io_addr(port.io_addr), .io_wdata(port.io_wdata),
    .level_mode(level_mode), .spacing_four(spacing_four), .auto_rotate(auto_rotate));

  task close_out;
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command, held until the host end takes it; returns two edges after the take,
  // so a write has landed in the device end and its effect is settled when checked.
  task xfer(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_data <= d;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    xfer(KIND_WRITE, a, d);
  endtask

  // The answer pulse stands only in the cycle after the second edge past the take.
  task rd(input logic [1:0] k, input logic [15:0] a, input logic [7:0] exp);
    xfer(k, a, 8'h00);
    @(negedge ref_clk);
    chk({7'h00, rsp_valid}, 8'h01);
    chk(rsp_data, exp);
    @(posedge ref_clk);
  endtask

  task irq(input logic [7:0] lines, input logic exp);
    irq_lines <= lines;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({7'h00, irq_pending}, {7'h00, exp});
    @(posedge ref_clk);
  endtask

  task init(input logic [7:0] w1);
    wr(CTRL_PORT, w1);
    // A control write offered while the sequence is open must be held off.
    @(negedge ref_clk);
    chk({7'h00, cmd_ready}, 8'h00);
    @(posedge ref_clk);
    wr(DATA_PORT, 8'h40);
    wr(DATA_PORT, 8'h00);
    wr(DATA_PORT, 8'h00);
  endtask

  // A hang in a handshake ends the run as a failure.
  initial begin
    repeat (2000) @(posedge ref_clk);
    mismatches++;
    close_out;
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    init(8'h1c);
    chk({6'h00, level_mode, spacing_four}, 8'h03);
    init(8'h10);
    chk({6'h00, level_mode, spacing_four}, 8'h00);
    wr(CTRL_PORT, 8'h80);
    chk({7'h00, auto_rotate}, 8'h01);
    wr(CTRL_PORT, 8'h00);
    chk({7'h00, auto_rotate}, 8'h00);
    wr(CTRL_PORT, 8'h0b);
    wr(DATA_PORT, 8'h08);
    rd(KIND_READ, DATA_PORT, 8'h08);
    irq(8'h08, 1'b0);
    wr(DATA_PORT, 8'h00);
    irq(8'h08, 1'b1);
    rd(KIND_ACK, CTRL_PORT, 8'h43);
    chk({2'h0, call_offset}, 8'h18);
    rd(KIND_READ, CTRL_PORT, 8'h08);
    wr(CTRL_PORT, 8'h40);
    rd(KIND_READ, CTRL_PORT, 8'h08);
    wr(CTRL_PORT, 8'h20);
    rd(KIND_READ, CTRL_PORT, 8'h00);
    irq(8'h28, 1'b1);
    rd(KIND_ACK, CTRL_PORT, 8'h45);
    wr(CTRL_PORT, 8'h65);
    rd(KIND_READ, CTRL_PORT, 8'h00);
    irq(8'h00, 1'b0);
    wr(CTRL_PORT, 8'hc3);
    irq(8'h24, 1'b1);
    rd(KIND_ACK, CTRL_PORT, 8'h45);
    wr(CTRL_PORT, 8'ha0);
    irq(8'h34, 1'b1);
    rd(KIND_ACK, CTRL_PORT, 8'h42);
    rd(KIND_READ, CTRL_PORT, 8'h04);
    wr(CTRL_PORT, 8'he2);
    rd(KIND_READ, CTRL_PORT, 8'h00);
    // Level triggering with the top bits set; the host end must send them as zero.
    init(8'hfc);
    irq(8'h34, 1'b1);
    irq(8'h00, 1'b0);
    irq(8'h10, 1'b1);
    rd(KIND_ACK, CTRL_PORT, 8'h44);
    chk({2'h0, call_offset}, 8'h10);
    close_out;
  end
endmodule
